// ### rtl/uus_defs.svh
// Constants for the user unit scaling block
`ifndef UUS_DEFS_SVH
`define UUS_DEFS_SVH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define UUS_POS_IDX      16'h60A8
`define UUS_SPD_IDX      16'h60A9
`define UUS_PAR_IDX      16'h0010
`define UUS_STAT_IDX     16'h0018
`define UUS_RES_IDX      16'h0019
`define UUS_GEAR_IDX     16'h001A
`define UUS_FEED_IDX     16'h001B
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define UUS_EXP_MSB      31
`define UUS_EXP_LSB      24
`define UUS_UNIT_MSB     23
`define UUS_UNIT_LSB     16
`define UUS_TIME_MSB     15
`define UUS_TIME_LSB     8
`define UUS_POS_MASK     32'hFFFF0000
`define UUS_SPD_MASK     32'hFFFFFF00
`define UUS_POS_RESET    32'hFF410000
`define UUS_SPD_RESET    32'h00B44700
`define UUS_RPM_WORD     32'h00B44700
`define UUS_PAR_RESET    32'h00000001
`define UUS_EXP_MAX      8'sh06
`define UUS_EXP_MIN      8'shFA
// ----------------------------------------------------------------
// Unit codes and turn scaling
// ----------------------------------------------------------------
`define UUS_U_DIMLESS    8'h00
`define UUS_U_METER      8'h01
`define UUS_U_INCH       8'hC1
`define UUS_U_FOOT       8'hC2
`define UUS_U_GRAD       8'h40
`define UUS_U_RAD        8'h10
`define UUS_U_DEG        8'h41
`define UUS_U_AMIN       8'h42
`define UUS_U_ASEC       8'h43
`define UUS_U_REV        8'hB4
`define UUS_U_INC        8'hB5
`define UUS_U_STEP       8'hAC
`define UUS_U_POLE       8'hC0
`define UUS_T_SEC        8'h03
`define UUS_T_MIN        8'h47
`define UUS_T_HOUR       8'h48
`define UUS_T_DAY        8'h49
`define UUS_T_YEAR       8'h4A
`define UUS_INC_SHIFT    16
`define UUS_STEP_2PH     4
`define UUS_STEP_3PH     6
`define UUS_FRAC_BITS    16
`endif

// ### rtl/uus_pkg.sv
// Types for the user unit scaling block
package uus_pkg;
  typedef enum logic [1:0] {UUS_CLS_LENGTH, UUS_CLS_ANGLE, UUS_CLS_RAW, UUS_CLS_BAD} uus_class_t;
  typedef enum logic [0:0] {UUS_DIV_LOAD, UUS_DIV_RUN} uus_div_t;
endpackage : uus_pkg

// ### rtl/uus_top.sv
// User unit decode, ratio derivation and operation-enabled hold-off
// What this block does
// - Parameter writes wait until operation-enabled ends
// - Length units apply gear and feed
// - Angle units apply gear, not feed
// - Increments: raw; open loop pp*65536
// - Steps: raw; pp*4 or pp*6
// - Electrical poles: raw; one pole pair
// - Time codes second to year, 365.25 days
// - Exponent two's complement, -6 to +6
// - Resolution is increments over motor revolutions
// - Gear is motor over driving shaft revolutions
// - Feed is feed over output shaft revolutions
// - Feed only for length or dimensionless
// - Position word: unit 23:16, exponent 31:24
// - Speed word: time 15:8, unit, exponent
// - Position word resets to tenth degree
// - Velocity mode forces rpm speed unit
// - Velocity factor is numerator over denominator
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "uus_defs.svh"
module uus_top
  import uus_pkg::*;
#(
  parameter int NPAR = 8
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  // AXI4-Lite slave
  input  wire logic [17:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [17:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Drive context
  input  wire logic        op_enabled_in,
  input  wire logic        velocity_mode_in,
  input  wire logic        open_loop_in,
  input  wire logic        three_phase_in,
  input  wire logic [7:0]  pole_pairs_in,
  // Scaling results
  output logic [31:0]      pos_unit_out,
  output logic [31:0]      speed_unit_out,
  output logic             gear_used_out,
  output logic             feed_used_out,
  output logic [31:0]      resolution_out,
  output logic [31:0]      gear_ratio_out,
  output logic [31:0]      feed_const_out,
  output logic [31:0]      vel_factor_num_out,
  output logic [31:0]      vel_factor_den_out,
  output logic [31:0]      turn_count_out,
  output logic [31:0]      time_secs_out
);
  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) rst_sync_reg <= 2'b00;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];
  // ----------------------------------------------------------------
  // Register storage: written copy and applied copy
  // ----------------------------------------------------------------
  logic [31:0] pos_wr_reg, spd_wr_reg, pos_act_reg, spd_act_reg;
  logic [31:0] par_wr_reg  [NPAR];
  logic [31:0] par_act_reg [NPAR];
  logic [31:0] res_q_reg, gear_q_reg, feed_q_reg;
  logic [2:0]  div0_reg;
  logic        hold_pend_reg;
  // ----------------------------------------------------------------
  // AXI4-Lite write: both channels taken together
  // ----------------------------------------------------------------
  logic        wr_go;
  logic [15:0] wr_idx;
  logic        wr_hit;
  logic [31:0] wmask;
  assign wr_go             = s_axi_awvalid_in & s_axi_wvalid_in & ~s_axi_bvalid_out;
  assign s_axi_awready_out = wr_go;
  assign s_axi_wready_out  = wr_go;
  assign wr_idx            = s_axi_awaddr_in[17:2];
  assign wr_hit = (wr_idx == `UUS_POS_IDX) || (wr_idx == `UUS_SPD_IDX) ||
                  (wr_idx[15:3] == `UUS_PAR_IDX >> 3);
  always_comb begin
    for (int b = 0; b < 4; b++) wmask[b*8 +: 8] = {8{s_axi_wstrb_in[b]}};
  end
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_hit ? 2'b00 : 2'b10;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pos_wr_reg <= `UUS_POS_RESET;
      spd_wr_reg <= `UUS_SPD_RESET;
      for (int i = 0; i < NPAR; i++) par_wr_reg[i] <= `UUS_PAR_RESET;
    end else if (wr_go) begin
      if (wr_idx == `UUS_POS_IDX)
        pos_wr_reg <= ((pos_wr_reg & ~wmask) | (s_axi_wdata_in & wmask)) & `UUS_POS_MASK;
      if (wr_idx == `UUS_SPD_IDX)
        spd_wr_reg <= ((spd_wr_reg & ~wmask) | (s_axi_wdata_in & wmask)) & `UUS_SPD_MASK;
      for (int i = 0; i < NPAR; i++)
        if (wr_idx == `UUS_PAR_IDX + 16'(i))
          par_wr_reg[i] <= (par_wr_reg[i] & ~wmask) | (s_axi_wdata_in & wmask);
    end
  end
  // ----------------------------------------------------------------
  // Hold-off: new values apply only outside operation enabled
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pos_act_reg <= `UUS_POS_RESET;
      spd_act_reg <= `UUS_SPD_RESET;
      for (int i = 0; i < NPAR; i++) par_act_reg[i] <= `UUS_PAR_RESET;
    end else if (!op_enabled_in) begin
      pos_act_reg <= pos_wr_reg;
      spd_act_reg <= spd_wr_reg;
      for (int i = 0; i < NPAR; i++) par_act_reg[i] <= par_wr_reg[i];
    end
  end
  logic pend;
  always_comb begin
    pend = (pos_wr_reg != pos_act_reg) || (spd_wr_reg != spd_act_reg);
    for (int i = 0; i < NPAR; i++) pend = pend | (par_wr_reg[i] != par_act_reg[i]);
  end
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) hold_pend_reg <= 1'b0;
    else hold_pend_reg <= op_enabled_in & pend;
  end
  // ----------------------------------------------------------------
  // Unit decode
  // ----------------------------------------------------------------
  logic [7:0]  pos_unit, time_unit;
  logic signed [7:0] pos_exp, spd_exp;
  uus_class_t  pos_cls;
  logic        exp_ok, time_ok;
  assign pos_unit  = pos_act_reg[`UUS_UNIT_MSB:`UUS_UNIT_LSB];
  assign pos_exp   = pos_act_reg[`UUS_EXP_MSB:`UUS_EXP_LSB];
  assign time_unit = speed_unit_out[`UUS_TIME_MSB:`UUS_TIME_LSB];
  assign spd_exp   = speed_unit_out[`UUS_EXP_MSB:`UUS_EXP_LSB];
  assign exp_ok    = (pos_exp <= `UUS_EXP_MAX) && (pos_exp >= `UUS_EXP_MIN) &&
                     (spd_exp <= `UUS_EXP_MAX) && (spd_exp >= `UUS_EXP_MIN);
  always_comb begin
    unique case (pos_unit)
      `UUS_U_DIMLESS, `UUS_U_METER, `UUS_U_INCH, `UUS_U_FOOT:
        pos_cls = UUS_CLS_LENGTH;
      `UUS_U_GRAD, `UUS_U_RAD, `UUS_U_DEG, `UUS_U_AMIN, `UUS_U_ASEC, `UUS_U_REV:
        pos_cls = UUS_CLS_ANGLE;
      `UUS_U_INC, `UUS_U_STEP, `UUS_U_POLE:
        pos_cls = UUS_CLS_RAW;
      default: pos_cls = UUS_CLS_BAD;
    endcase
  end
  // Raw units per turn, from the pole pair count; closed-loop increments take it from the resolution
  always_comb begin
    unique case (pos_unit)
      `UUS_U_INC:  turn_count_out = open_loop_in ? {8'h00, pole_pairs_in, 16'h0000}
                                                 : {16'h0000, res_q_reg[31:16]};
      `UUS_U_STEP: turn_count_out = 32'(pole_pairs_in) *
                                    (three_phase_in ? 32'(`UUS_STEP_3PH) : 32'(`UUS_STEP_2PH));
      `UUS_U_POLE: turn_count_out = 32'(pole_pairs_in);
      default:     turn_count_out = 32'h00000000;
    endcase
  end
  // Seconds per time unit; a year is 365.25 days
  always_comb begin
    time_ok = 1'b1;
    unique case (time_unit)
      `UUS_T_SEC:  time_secs_out = 32'd1;
      `UUS_T_MIN:  time_secs_out = 32'd60;
      `UUS_T_HOUR: time_secs_out = 32'd3600;
      `UUS_T_DAY:  time_secs_out = 32'd86400;
      `UUS_T_YEAR: time_secs_out = 32'd31557600;
      default: begin
        time_secs_out = 32'h00000000;
        time_ok       = 1'b0;
      end
    endcase
  end
  assign pos_unit_out       = pos_act_reg;
  assign speed_unit_out     = velocity_mode_in ? `UUS_RPM_WORD : spd_act_reg;
  assign gear_used_out      = (pos_cls == UUS_CLS_LENGTH) || (pos_cls == UUS_CLS_ANGLE);
  assign feed_used_out      = (pos_cls == UUS_CLS_LENGTH);
  assign resolution_out     = res_q_reg;
  assign gear_ratio_out     = gear_used_out ? gear_q_reg : 32'h00010000;
  assign feed_const_out     = feed_used_out ? feed_q_reg : 32'h00010000;
  assign vel_factor_num_out = par_act_reg[6];
  assign vel_factor_den_out = par_act_reg[7];
  // ----------------------------------------------------------------
  // Shared divider, 16.16 quotients, cycles over three ratios
  // ----------------------------------------------------------------
  // One serial divider saves area; results lag a change by up to 4 x 50 cycles.
  localparam int DW = 32 + `UUS_FRAC_BITS;
  uus_div_t    div_st_reg;
  logic [1:0]  job_reg;
  logic [5:0]  cnt_reg;
  logic [DW-1:0] num_reg, quo_reg;
  logic [31:0] den_reg;
  logic [32:0] rem_reg;
  logic [32:0] rem_sh;
  assign rem_sh = {rem_reg[31:0], num_reg[DW-1]};
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      div_st_reg <= UUS_DIV_LOAD;
      job_reg    <= 2'd0;
      cnt_reg    <= 6'd0;
      num_reg    <= '0;
      quo_reg    <= '0;
      den_reg    <= 32'h00000000;
      rem_reg    <= 33'h000000000;
      res_q_reg  <= 32'h00010000;
      gear_q_reg <= 32'h00010000;
      feed_q_reg <= 32'h00010000;
      div0_reg   <= 3'b000;
    end else begin
      unique case (div_st_reg)
        UUS_DIV_LOAD: begin
          num_reg    <= {par_act_reg[{job_reg, 1'b0}], 16'h0000};
          den_reg    <= par_act_reg[{job_reg, 1'b1}];
          rem_reg    <= 33'h000000000;
          cnt_reg    <= 6'(DW);
          div_st_reg <= UUS_DIV_RUN;
        end
        UUS_DIV_RUN: begin
          num_reg <= {num_reg[DW-2:0], 1'b0};
          if (rem_sh >= {1'b0, den_reg}) begin
            rem_reg <= rem_sh - {1'b0, den_reg};
            quo_reg <= {quo_reg[DW-2:0], 1'b1};
          end else begin
            rem_reg <= rem_sh;
            quo_reg <= {quo_reg[DW-2:0], 1'b0};
          end
          cnt_reg <= cnt_reg - 6'd1;
          if (cnt_reg == 6'd0) begin
            // Zero divisor or overflow saturates
            div0_reg[job_reg] <= (den_reg == 32'h00000000);
            unique case (job_reg)
              2'd0:    res_q_reg  <= (quo_reg[DW-1:32] != 16'h0000) ? 32'hFFFFFFFF : quo_reg[31:0];
              2'd1:    gear_q_reg <= (quo_reg[DW-1:32] != 16'h0000) ? 32'hFFFFFFFF : quo_reg[31:0];
              default: feed_q_reg <= (quo_reg[DW-1:32] != 16'h0000) ? 32'hFFFFFFFF : quo_reg[31:0];
            endcase
            job_reg    <= (job_reg == 2'd2) ? 2'd0 : job_reg + 2'd1;
            div_st_reg <= UUS_DIV_LOAD;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read
  // ----------------------------------------------------------------
  logic [15:0] rd_idx;
  assign rd_idx            = s_axi_araddr_in[17:2];
  assign s_axi_arready_out = ~s_axi_rvalid_out;
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h00000000;
      s_axi_rresp_out  <= 2'b00;
    end else if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out  <= 2'b00;
      s_axi_rdata_out  <= 32'h00000000;
      if (rd_idx == `UUS_POS_IDX) s_axi_rdata_out <= pos_wr_reg;
      else if (rd_idx == `UUS_SPD_IDX) s_axi_rdata_out <= spd_wr_reg;
      else if (rd_idx[15:3] == `UUS_PAR_IDX >> 3) s_axi_rdata_out <= par_wr_reg[rd_idx[2:0]];
      else if (rd_idx == `UUS_STAT_IDX)
        s_axi_rdata_out <= {22'h000000, div0_reg, pos_cls, time_ok, exp_ok,
                            feed_used_out, gear_used_out, hold_pend_reg};
      else if (rd_idx == `UUS_RES_IDX) s_axi_rdata_out <= res_q_reg;
      else if (rd_idx == `UUS_GEAR_IDX) s_axi_rdata_out <= gear_q_reg;
      else if (rd_idx == `UUS_FEED_IDX) s_axi_rdata_out <= feed_q_reg;
      else s_axi_rresp_out <= 2'b10;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  hold_stable_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    op_enabled_in |=> $stable(pos_act_reg) && $stable(spd_act_reg))
    else $error("applied unit words changed while operation enabled");
  commit_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    !op_enabled_in |=> pos_act_reg == $past(pos_wr_reg))
    else $error("written position word not applied outside operation enabled");
  length_feed_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    (pos_unit == `UUS_U_INCH) |-> gear_used_out && feed_used_out)
    else $error("length unit lacks gear or feed");
  angle_nofeed_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    (pos_unit == `UUS_U_DEG) |-> gear_used_out && !feed_used_out && feed_const_out == 32'h00010000)
    else $error("angle unit applies feed or lacks gear");
  raw_units_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    (pos_unit == `UUS_U_INC && open_loop_in) |-> !gear_used_out &&
      turn_count_out == {8'h00, pole_pairs_in, 16'h0000})
    else $error("increment turn count wrong");
  step_count_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    (pos_unit == `UUS_U_STEP && three_phase_in) |-> turn_count_out == 32'(pole_pairs_in) * 32'd6)
    else $error("step turn count wrong");
  year_secs_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    (time_unit == `UUS_T_YEAR) |-> time_secs_out == 32'd31557600)
    else $error("year length wrong");
  reserved_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    pos_wr_reg[15:0] == 16'h0000 && spd_wr_reg[7:0] == 8'h00)
    else $error("reserved unit bits not zero");
  vel_rpm_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    velocity_mode_in |-> speed_unit_out == `UUS_RPM_WORD)
    else $error("velocity mode speed unit not rpm");
  bresp_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    wr_go || (s_axi_bvalid_out && !s_axi_bready_in) |=> s_axi_bvalid_out)
    else $error("write response missing");
endmodule : uus_top
`default_nettype wire

// ### sim/user_unit_scaling_tb.sv
// Self-checking bench for the user unit scaling block
`timescale 1ns/100ps
`default_nettype none
`include "uus_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin $display("ERROR %s expected %h got %h", nm, e, g); err_total++; end end
module user_unit_scaling_tb;
  typedef struct {logic [31:0] dat; logic [31:0] msk; logic [1:0] rsp;} uus_note_t;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        op_en, vel_mode, open_loop, three_ph, gear_used, feed_used;
  logic [7:0]  pp;
  logic [31:0] pos_u, spd_u, res_q, gear_q, feed_q, vnum, vden, turns, tsecs, texp;
  int          err_total, cmp_count, cyc, i, r, k;
  uus_note_t   wq[$], rq[$], n;
  logic [7:0]  ucode[14] = '{8'h01, 8'hC1, 8'hC2, 8'h00, 8'h40, 8'h10, 8'h41, 8'h42, 8'h43,
                             8'hB4, 8'hB5, 8'hAC, 8'hC0, 8'h55};
  logic [1:0]  ugf[14]   = '{3, 3, 3, 3, 2, 2, 2, 2, 2, 2, 0, 0, 0, 0};
  logic [7:0]  tcode[5]  = '{8'h03, 8'h47, 8'h48, 8'h49, 8'h4A};
  logic [31:0] tsec[5]   = '{1, 60, 3600, 86400, 31557600};
  logic [7:0]  ecode[4]  = '{8'h06, 8'hFA, 8'h07, 8'hF9};
  logic        eok[4]    = '{1, 1, 0, 0};

  uus_top DUT (
    .sys_clk_in(clk), .reset_n_in(rst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .op_enabled_in(op_en), .velocity_mode_in(vel_mode), .open_loop_in(open_loop),
    .three_phase_in(three_ph), .pole_pairs_in(pp),
    .pos_unit_out(pos_u), .speed_unit_out(spd_u), .gear_used_out(gear_used),
    .feed_used_out(feed_used), .resolution_out(res_q), .gear_ratio_out(gear_q),
    .feed_const_out(feed_q), .vel_factor_num_out(vnum), .vel_factor_den_out(vden),
    .turn_count_out(turns), .time_secs_out(tsecs)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus tasks and closing
  // ----------------------------------------------------------------
  function automatic logic [17:0] ba(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction : ba

  task automatic conclude();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // Ready is looked at on the falling edge so the take edge is never raced
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] rsp);
    wq.push_back('{32'h0, 32'h0, rsp});
    @(posedge clk);
    awaddr <= ba(idx);
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge clk); while (awready !== 1'b1 || wready !== 1'b1);
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk); while (bvalid !== 1'b1);
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] rsp);
    rq.push_back('{e, m, rsp});
    @(posedge clk);
    araddr <= ba(idx);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    @(posedge clk);
    rready <= 1'b0;
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Responses are matched against the oldest note
  always @(negedge clk) begin
    if (bvalid === 1'b1 && bready) begin
      if (wq.size() == 0) begin
        `CHK("bvalid", 1'b0, bvalid)
      end else begin
        n = wq.pop_front();
        `CHK("bresp", n.rsp, bresp)
      end
    end
    if (rvalid === 1'b1 && rready) begin
      if (rq.size() == 0) begin
        `CHK("rvalid", 1'b0, rvalid)
      end else begin
        n = rq.pop_front();
        `CHK("rresp", n.rsp, rresp)
        `CHK("rdata", n.dat, rdata & n.msk)
      end
    end
  end

  // Hang guard, well above the fewer than a thousand cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, op_en, vel_mode, three_ph} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    open_loop = 1'b1;
    cyc = 0;
    r = $urandom(32'h5a141fe0);
    pp = 8'($urandom_range(1, 255));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK("pos_unit", `UUS_POS_RESET, pos_u)
    rd(`UUS_POS_IDX, `UUS_POS_RESET, '1, 2'b00);
    rd(`UUS_SPD_IDX, `UUS_SPD_RESET, '1, 2'b00);
    rd(`UUS_PAR_IDX, 32'h1, '1, 2'b00);
    for (i = 0; i < 14; i++) begin
      @(posedge clk);
      three_ph <= 1'($urandom_range(0, 1));
      wr(`UUS_POS_IDX, {8'h00, ucode[i], 16'h0000}, 2'b00);
      settle();
      case (ucode[i])
        8'hB5: texp = {8'h00, pp, 16'h0000};
        8'hAC: texp = 32'(pp) * (three_ph ? 6 : 4);
        8'hC0: texp = 32'(pp);
        default: texp = 32'h0;
      endcase
      `CHK("gear_used", ugf[i][1], gear_used)
      `CHK("feed_used", ugf[i][0], feed_used)
      `CHK("turn_count", texp, turns)
    end
    for (i = 0; i < 5; i++) begin
      wr(`UUS_SPD_IDX, {8'h00, 8'hB4, tcode[i], 8'h00}, 2'b00);
      settle();
      `CHK("time_secs", tsec[i], tsecs)
      `CHK("speed_unit", {8'h00, 8'hB4, tcode[i], 8'h00}, spd_u)
    end
    @(posedge clk);
    vel_mode <= 1'b1;
    settle();
    `CHK("speed_unit", `UUS_RPM_WORD, spd_u)
    @(posedge clk);
    vel_mode <= 1'b0;
    for (i = 0; i < 4; i++) begin
      wr(`UUS_POS_IDX, {ecode[i], 8'h41, 16'h0000}, 2'b00);
      settle();
      rd(`UUS_STAT_IDX, {28'h0, eok[i], 3'b000}, 32'h8, 2'b00);
    end
    // Reserved bits are written nonzero on purpose
    wr(`UUS_POS_IDX, 32'hFD01ABCD, 2'b00);
    rd(`UUS_POS_IDX, 32'hFD010000, '1, 2'b00);
    wr(`UUS_SPD_IDX, 32'hFD0103FF, 2'b00);
    rd(`UUS_SPD_IDX, 32'hFD010300, '1, 2'b00);
    settle();
    @(posedge clk);
    op_en <= 1'b1;
    wr(`UUS_POS_IDX, 32'hFE410000, 2'b00);
    repeat (5) @(posedge clk);
    @(negedge clk);
    `CHK("pos_unit", 32'hFD010000, pos_u)
    rd(`UUS_STAT_IDX, 32'h1, 32'h1, 2'b00);
    op_en <= 1'b0;
    settle();
    `CHK("pos_unit", 32'hFE410000, pos_u)
    r = $urandom_range(1, 8);
    k = $urandom_range(1, 4000);
    wr(16'h0010, 32'(r * k), 2'b00);
    wr(16'h0011, 32'(r), 2'b00);
    wr(16'h0012, 32'h3, 2'b00);
    wr(16'h0013, 32'h2, 2'b00);
    wr(16'h0014, 32'h5, 2'b00);
    wr(16'h0015, 32'h2, 2'b00);
    wr(`UUS_POS_IDX, 32'h00010000, 2'b00);
    repeat (200) @(posedge clk);
    @(negedge clk);
    `CHK("resolution", 32'(k) << 16, res_q)
    `CHK("gear_ratio", 32'h00018000, gear_q)
    `CHK("feed_const", 32'h00028000, feed_q)
    rd(`UUS_RES_IDX, 32'(k) << 16, '1, 2'b00);
    wr(`UUS_POS_IDX, 32'h00410000, 2'b00);
    repeat (200) @(posedge clk);
    @(negedge clk);
    `CHK("feed_const", 32'h00010000, feed_q)
    `CHK("gear_ratio", 32'h00018000, gear_q)
    wr(16'h0016, 32'h1, 2'b00);
    wr(16'h0017, 32'h3, 2'b00);
    settle();
    `CHK("vel_num", 32'h1, vnum)
    `CHK("vel_den", 32'h3, vden)
    // Closed loop: increments per turn follow the resolution
    @(posedge clk);
    open_loop <= 1'b0;
    wr(`UUS_POS_IDX, 32'h00B50000, 2'b00);
    settle();
    `CHK("turn_count", 32'(k), turns)
    // Unmapped place: refused with an error, nothing stored
    wr(16'h0100, 32'h12345678, 2'b10);
    rd(16'h0100, 32'h0, '1, 2'b10);
    conclude();
  end
endmodule : user_unit_scaling_tb
`default_nettype wire
